// ===== pkg/qcti_pkg.sv
// Constants and types shared by the quadrature counter and timer interrupt block
package qcti_pkg;

    // Bus and datapath widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 16;
    localparam int NCH    = 3;
    localparam int NQUAD  = 2;
    localparam int NSRC   = 13;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL  = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STAT0 = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_STAT1 = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_STAT2 = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_ENA0  = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_ENA1  = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_ENA2  = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_CNT1  = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_CNT2  = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_STEP  = 8'h04;

    // Status and enable bit positions, identical layout
    localparam int BIT_MA  = 0;
    localparam int BIT_OVF = 4;
    localparam int BIT_UNF = 5;
    localparam int BIT_DIR = 6;
    localparam int BIT_ADT = 7;

    // Implemented sources per channel, channel 0 in the low six bits
    localparam logic [17:0] SRC_MASKS = 18'h33CDF;
    localparam logic [1:0]  ENA_EXTRA = 2'h2;

    // Control register: per quadrature channel an enable and a mode
    localparam int          CTRL_EN_POS   = 0;
    localparam int          CTRL_MODE_POS = 1;
    localparam int          CTRL_STRIDE   = 4;
    localparam logic [7:0]  CTRL_MASK     = 8'h77;

    // Reset values
    localparam logic [7:0]       CTRL_RST = 8'h00;
    localparam logic [7:0]       ENA_RST  = 8'h00;
    localparam logic [5:0]       FLAG_RST = 6'h00;
    localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;
    localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;

    // Phase counting modes
    typedef enum logic [1:0] {
        QCTI_MODE1 = 2'h0,
        QCTI_MODE2 = 2'h1,
        QCTI_MODE3 = 2'h3,
        QCTI_MODE4 = 2'h2
    } qcti_mode_t;

endpackage : qcti_pkg

// ===== rtl/qcti_top.sv
// Quadrature decoder for channels 1 and 2 with timer interrupt, DMA and ADC request logic
//
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RULE_01] Mode 1 counts up on the four forward edge/level pairs of phases A,B or C,D.
// [RULE_02] Mode 1 counts down on the four reverse edge/level pairs.
// [RULE_03] Mode 2 counts only on first-phase fall: up if second high, down if low.
// [RULE_04] Mode 3: up on first-phase fall with second high, down on second fall, first high.
// [RULE_05] Mode 4 counts only on second-phase edges; first-phase edges never count.
// [RULE_06] Match, overflow and underflow sources each own a flag and enable bit.
// [RULE_07] An event sets its flag; request is high while flag and enable are both one.
// [RULE_08] A request is withdrawn by clearing its flag to zero.
// [RULE_09] Fixed priority: match A to D, overflow, underflow; channel 0 highest.
// [RULE_10] Eight match interrupts: four on channel 0, two on channels 1 and 2.
// [RULE_11] Every channel has an overflow request gated by its overflow enable.
// [RULE_12] Only channels 1 and 2 have an underflow request.
// [RULE_13] Only the match-A source of each channel may activate the DMA controller.
// [RULE_14] Match A with converter trigger enabled sends a conversion start request.
// [RULE_15] The converter starts only if it selected the timer trigger.
// [RULE_16] Quadrature only on channels 1 and 2; clear and interrupts stay active.
// [RULE_17] Down-count wrap sets underflow; a readable flag shows the count direction.
// [RULE_18] Software clears a flag read as one by writing zero; DMA service clears it.
// [RULE_19] Phase inputs are synchronised and edges found by comparing successive samples.
module qcti_top
    import qcti_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // Avalon-MM register slave
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [DATA_W-1:0] writedata,
    input  wire logic [3:0]        byteenable,
    output logic      [DATA_W-1:0] readdata,
    output logic                   waitrequest,
    // Encoder phase inputs
    input  wire logic              phaseInA,
    input  wire logic              phaseInB,
    input  wire logic              phaseInC,
    input  wire logic              phaseInD,
    // Events from the counter and compare datapath
    input  wire logic [4*NCH-1:0]  matchEvt,
    input  wire logic [NCH-1:0]    ovfEvt,
    input  wire logic [NQUAD-1:0]  unfEvt,
    input  wire logic [NQUAD-1:0]  cntClear,
    input  wire logic [NCH-1:0]    dmaAck,
    // Requests to interrupt, DMA and conversion logic
    output logic      [NSRC-1:0]   irqReq,
    output logic      [3:0]        irqVector,
    output logic                   irq,
    output logic      [NCH-1:0]    dmaReq,
    output logic      [NCH-1:0]    adcStart
);

    logic                   busDone;
    logic                   wrDone;
    logic [7:0]             ctrl;
    logic [3:0]             phSync1;
    logic [3:0]             phSync2;
    logic [3:0]             phPrev;
    logic [CNT_W-1:0]       qCnt   [NQUAD];
    logic [NQUAD-1:0]       qDir;
    logic [NQUAD-1:0]       qOvf;
    logic [NQUAD-1:0]       qUnf;
    logic [5:0]             flag   [NCH];
    logic [5:0]             seen   [NCH];
    logic [5:0]             setv   [NCH];
    logic [5:0]             reqNow [NCH];
    logic [7:0]             ena    [NCH];
    logic [NSRC-1:0]        reqFlat;
    logic [DATA_W-1:0]      next_readdata;

    default clocking cbSys @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // One wait cycle for every access; completion is the edge with wait low
    assign busDone = (read || write) && !waitrequest;
    assign wrDone  = write && !waitrequest && byteenable[0];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            waitrequest <= 1'b1;
        end else if (!waitrequest) begin
            waitrequest <= 1'b1;
        end else if (read || write) begin
            waitrequest <= 1'b0;
        end
    end

    a_wait_one : assert property (
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("access not answered after one wait cycle");

    always_comb begin
        next_readdata = '0;
        if (address == OFF_CTRL) begin
            next_readdata = DATA_W'(ctrl);
        end else if (address == OFF_STAT0) begin
            next_readdata = DATA_W'(flag[0]);
        end else if (address == OFF_STAT1) begin
            next_readdata = DATA_W'({qDir[0], flag[1]}); // RULE_17
        end else if (address == OFF_STAT2) begin
            next_readdata = DATA_W'({qDir[1], flag[2]}); // RULE_17
        end else if (address == OFF_ENA0) begin
            next_readdata = DATA_W'(ena[0]);
        end else if (address == OFF_ENA1) begin
            next_readdata = DATA_W'(ena[1]);
        end else if (address == OFF_ENA2) begin
            next_readdata = DATA_W'(ena[2]);
        end else if (address == OFF_CNT1) begin
            next_readdata = DATA_W'(qCnt[0]);
        end else if (address == OFF_CNT2) begin
            next_readdata = DATA_W'(qCnt[1]);
        end
    end

    // Data is latched with the wait drop so it stands at the completing edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            readdata <= '0;
        end else if (read && waitrequest) begin
            readdata <= next_readdata;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl <= CTRL_RST;
        end else if (wrDone && address == OFF_CTRL) begin
            ctrl <= writedata[7:0] & CTRL_MASK;
        end
    end

    // Only phSync2 and phPrev feed the edge detectors
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phSync1 <= 4'h0;
            phSync2 <= 4'h0;
            phPrev  <= 4'h0;
        end else begin
            phSync1 <= {phaseInD, phaseInC, phaseInB, phaseInA}; // RULE_19
            phSync2 <= phSync1;
            phPrev  <= phSync2; // RULE_19
        end
    end

    for (genvar q = 0; q < NQUAD; q++) begin : gen_quad
        logic       quadEn;
        logic       lvlA;
        logic       lvlB;
        logic       riseA;
        logic       fallA;
        logic       riseB;
        logic       fallB;
        logic       up;
        logic       dn;
        qcti_mode_t mode;

        assign quadEn = ctrl[CTRL_EN_POS + CTRL_STRIDE*q]; // RULE_16
        assign mode   = qcti_mode_t'(ctrl[CTRL_MODE_POS + CTRL_STRIDE*q +: 2]);
        assign lvlA   = phSync2[2*q];
        assign lvlB   = phSync2[2*q+1];
        assign riseA  = lvlA && !phPrev[2*q];
        assign fallA  = !lvlA && phPrev[2*q];
        assign riseB  = lvlB && !phPrev[2*q+1];
        assign fallB  = !lvlB && phPrev[2*q+1];

        always_comb begin
            up = 1'b0;
            dn = 1'b0;
            case (mode)
                QCTI_MODE1: begin
                    up = (riseB && lvlA) || (fallB && !lvlA)
                      || (riseA && !lvlB) || (fallA && lvlB); // RULE_01
                    dn = (fallB && lvlA) || (riseB && !lvlA)
                      || (riseA && lvlB) || (fallA && !lvlB); // RULE_02
                end
                QCTI_MODE2: begin
                    up = fallA && lvlB; // RULE_03
                    dn = fallA && !lvlB; // RULE_03
                end
                QCTI_MODE3: begin
                    up = fallA && lvlB; // RULE_04
                    dn = fallB && lvlA; // RULE_04
                end
                default: begin
                    up = (riseB && lvlA) || (fallB && !lvlA); // RULE_05
                    dn = (fallB && lvlA) || (riseB && !lvlA); // RULE_05
                end
            endcase
        end

        // A clear in the same cycle hides the wrap, so no flag is set
        assign qOvf[q] = quadEn && up && !cntClear[q] && qCnt[q] == CNT_MAX;
        assign qUnf[q] = quadEn && dn && !cntClear[q] && qCnt[q] == CNT_RST;

        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                qCnt[q] <= CNT_RST;
                qDir[q] <= 1'b1;
            end else if (cntClear[q]) begin
                qCnt[q] <= CNT_RST; // RULE_16
            end else if (quadEn && up) begin
                qCnt[q] <= qCnt[q] + CNT_ONE;
                qDir[q] <= 1'b1; // RULE_17
            end else if (quadEn && dn) begin
                qCnt[q] <= qCnt[q] - CNT_ONE;
                qDir[q] <= 1'b0; // RULE_17
            end
        end

        a_m1_up : assert property ( // RULE_01
            quadEn && mode == QCTI_MODE1 && !cntClear[q]
            && ((riseB && lvlA) || (fallA && lvlB))
            |=> qCnt[q] == CNT_W'($past(qCnt[q]) + CNT_ONE) && qDir[q])
            else $error("mode 1 forward edge did not count up");
        a_m1_dn : assert property ( // RULE_02
            quadEn && mode == QCTI_MODE1 && !cntClear[q]
            && ((riseA && lvlB) || (fallB && lvlA))
            |=> qCnt[q] == CNT_W'($past(qCnt[q]) - CNT_ONE) && !qDir[q])
            else $error("mode 1 reverse edge did not count down");
        a_m2_hold : assert property ( // RULE_03
            mode == QCTI_MODE2 && !fallA && !cntClear[q]
            |=> $stable(qCnt[q]))
            else $error("mode 2 counted without a first-phase fall");
        a_m3_dn : assert property ( // RULE_04
            quadEn && mode == QCTI_MODE3 && fallB && lvlA && !fallA
            && !cntClear[q]
            |=> qCnt[q] == CNT_W'($past(qCnt[q]) - CNT_ONE))
            else $error("mode 3 second-phase fall did not count down");
        a_m4_hold : assert property ( // RULE_05
            mode == QCTI_MODE4 && !riseB && !fallB && !cntClear[q]
            |=> $stable(qCnt[q]))
            else $error("mode 4 counted on a first-phase edge");
        a_unf : assert property ( // RULE_17
            qUnf[q] |=> flag[q+1][BIT_UNF] && qCnt[q] == CNT_MAX && !qDir[q])
            else $error("down wrap did not set underflow");
        a_off : assert property ( // RULE_16
            !quadEn && !cntClear[q] |=> $stable(qCnt[q]))
            else $error("counter moved with decoding off");
    end

    for (genvar c = 0; c < NCH; c++) begin : gen_ch
        localparam logic [5:0] MASK = SRC_MASKS[6*c +: 6];
        localparam logic [7:0] EMASK = {ENA_EXTRA, MASK};
        localparam logic [ADDR_W-1:0] A_STAT =
            OFF_STAT0 + ADDR_W'(c) * OFF_STEP;
        localparam logic [ADDR_W-1:0] A_ENA =
            OFF_ENA0 + ADDR_W'(c) * OFF_STEP;
        logic       ovfE;
        logic       unfE;
        logic [5:0] cpuClr;
        logic [5:0] dmaClr;

        if (c == 0) begin : gen_plain
            assign ovfE = ovfEvt[0];
            assign unfE = 1'b0; // RULE_12
        end else begin : gen_quadsrc
            assign ovfE = ovfEvt[c] || qOvf[c-1]; // RULE_11
            assign unfE = unfEvt[c-1] || qUnf[c-1]; // RULE_12
        end

        assign setv[c] = {unfE, ovfE, matchEvt[4*c +: 4]} & MASK; // RULE_10
        // Only bits that were returned as one may be cleared by a zero
        assign cpuClr = (wrDone && address == A_STAT)
                      ? (seen[c] & ~writedata[5:0]) : 6'h00; // RULE_18
        assign dmaClr = {5'h00, dmaAck[c]}; // RULE_18
        assign reqNow[c] = flag[c] & ena[c][5:0]; // RULE_07

        // Set beats clear so an event in the clearing cycle survives
        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                flag[c] <= FLAG_RST;
            end else begin
                flag[c] <= ((flag[c] & ~(cpuClr | dmaClr)) | setv[c]) & MASK; // RULE_06
            end
        end

        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                seen[c] <= FLAG_RST;
            end else if (read && waitrequest && address == A_STAT) begin
                seen[c] <= flag[c]; // RULE_18
            end else if (write && busDone && address == A_STAT) begin
                seen[c] <= FLAG_RST;
            end
        end

        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                ena[c] <= ENA_RST;
            end else if (wrDone && address == A_ENA) begin
                ena[c] <= writedata[7:0] & EMASK; // RULE_06
            end
        end

        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                dmaReq[c]   <= 1'b0;
                adcStart[c] <= 1'b0;
            end else begin
                dmaReq[c]   <= reqNow[c][BIT_MA]; // RULE_13
                adcStart[c] <= setv[c][BIT_MA] && ena[c][BIT_ADT]; // RULE_14
            end
        end

        a_set : assert property ( // RULE_07
            setv[c] != 6'h00 |=> (flag[c] & $past(setv[c])) == $past(setv[c]))
            else $error("event did not set its flag");
        a_src : assert property ( // RULE_07
            flag[c][BIT_MA] && ena[c][BIT_MA] |=> irq && dmaReq[c])
            else $error("enabled match A flag gave no request");
        a_dma_clr : assert property ( // RULE_18
            dmaAck[c] && !setv[c][BIT_MA] |=> !flag[c][BIT_MA] ##1 !dmaReq[c])
            else $error("DMA service did not clear match A");
        a_hold : assert property ( // RULE_08
            flag[c][BIT_OVF] && !(wrDone && address == A_STAT)
            |=> flag[c][BIT_OVF])
            else $error("overflow flag dropped without a clear");
        a_adc : assert property ( // RULE_14
            matchEvt[4*c] && ena[c][BIT_ADT] |=> adcStart[c] ##1 !adcStart[c]
            || $past(matchEvt[4*c]))
            else $error("conversion start missing or stretched");
    end

    // Flat source order is the fixed priority order, index 0 highest
    assign reqFlat = {reqNow[2][5:4], reqNow[2][1:0],
                      reqNow[1][5:4], reqNow[1][1:0],
                      reqNow[0][4:0]}; // RULE_09

    function automatic logic [3:0] qcti_prio(input logic [NSRC-1:0] req);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irqReq    <= '0;
            irq       <= 1'b0;
            irqVector <= 4'h0;
        end else begin
            irqReq    <= reqFlat; // RULE_07
            irq       <= |reqFlat; // RULE_08
            irqVector <= qcti_prio(reqFlat); // RULE_09
        end
    end

    a_prio : assert property ( // RULE_09
        irq |-> irqReq[irqVector]
        && (irqReq & ((NSRC'(1) << irqVector) - NSRC'(1))) == '0)
        else $error("vector is not the highest pending source");

endmodule // qcti_top
`default_nettype wire

// ===== verification/qcti_partner.sv
// Encoder, DMA controller and converter models for the quadrature timer bench
`timescale 1ns/1ps
`default_nettype none
module qcti_partner
    import qcti_pkg::*;
(
    // Clock and reset
    input  wire logic           clk_sys,
    input  wire logic           rst,
    // Encoder step command and phases
    input  wire logic           stepGo,
    input  wire logic           stepCh,
    input  wire logic           stepFwd,
    output logic                phaseInA,
    output logic                phaseInB,
    output logic                phaseInC,
    output logic                phaseInD,
    // DMA controller handshake
    input  wire logic           dmaEn,
    input  wire logic           dmaSlow,
    input  wire logic [NCH-1:0] dmaReq,
    output logic      [NCH-1:0] dmaAck,
    // Converter start model
    input  wire logic [NCH-1:0] adcStart,
    input  wire logic           adcSelTimer,
    output logic      [7:0]     convCnt
);
    logic [1:0] ph [NQUAD];
    logic [3:0] dmaWait [NCH];

    assign {phaseInA, phaseInB} = ph[0];
    assign {phaseInC, phaseInD} = ph[1];

    // Gray steps: one phase moves at a time, never both together
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ph <= '{2'h0, 2'h0};
        end else if (stepGo) begin
            ph[stepCh] <= stepFwd ? {ph[stepCh][0], ~ph[stepCh][1]}
                                  : {~ph[stepCh][0], ph[stepCh][1]};
        end
    end

    // Ack after a delay, then stay deaf while the request drains
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dmaAck  <= '0;
            dmaWait <= '{4'h0, 4'h0, 4'h0};
        end else begin
            for (int c = 0; c < NCH; c++) begin
                dmaAck[c] <= dmaWait[c] == 4'h5;
                if (dmaWait[c] != 4'h0)
                    dmaWait[c] <= dmaWait[c] - 4'h1;
                else if (dmaReq[c] && dmaEn)
                    dmaWait[c] <= dmaSlow ? 4'hC : 4'h6;
            end
        end
    end

    // Converter counts a start only while the timer trigger is selected
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            convCnt <= 8'h00;
        end else if (adcSelTimer && adcStart != '0) begin
            convCnt <= convCnt + 8'h01;
        end
    end
endmodule // qcti_partner
`default_nettype wire

// ===== verification/quadrature_count_and_timer_irq_tb.sv
// Self-checking bench for the quadrature count and timer interrupt block
`timescale 1ns/1ps
`default_nettype none
module quadrature_count_and_timer_irq_tb
    import qcti_pkg::*;
;
    logic              clk_sys = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] address = '0;
    logic              read = 1'b0;
    logic              write = 1'b0;
    logic [DATA_W-1:0] writedata = '0;
    logic [DATA_W-1:0] readdata, rd;
    logic              waitrequest, irq;
    logic              phaseInA, phaseInB, phaseInC, phaseInD;
    logic [4*NCH-1:0]  matchEvt = '0;
    logic [NCH-1:0]    ovfEvt = '0;
    logic [NQUAD-1:0]  unfEvt = '0;
    logic [NQUAD-1:0]  cntClear = '0;
    logic [NCH-1:0]    dmaAck, dmaReq, adcStart;
    logic [NSRC-1:0]   irqReq;
    logic [3:0]        irqVector;
    logic              stepGo = 1'b0, stepCh = 1'b0, stepFwd = 1'b0;
    logic              dmaEn = 1'b0, dmaSlow = 1'b0;
    logic              adcSel = 1'b0;
    logic [7:0]        convCnt;
    logic [31:0]       seed = 32'h00007EF6;
    int                error_cnt = 0;
    int                checks = 0;

    qcti_top i_dut (.clk_sys(clk_sys), .rst(rst), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
        .phaseInA(phaseInA), .phaseInB(phaseInB), .phaseInC(phaseInC),
        .phaseInD(phaseInD), .matchEvt(matchEvt), .ovfEvt(ovfEvt),
        .unfEvt(unfEvt), .cntClear(cntClear), .dmaAck(dmaAck),
        .irqReq(irqReq), .irqVector(irqVector), .irq(irq),
        .dmaReq(dmaReq), .adcStart(adcStart));
    qcti_partner i_partner (.clk_sys(clk_sys), .rst(rst), .stepGo(stepGo),
        .stepCh(stepCh), .stepFwd(stepFwd), .phaseInA(phaseInA),
        .phaseInB(phaseInB), .phaseInC(phaseInC), .phaseInD(phaseInD),
        .dmaEn(dmaEn), .dmaSlow(dmaSlow), .dmaReq(dmaReq), .dmaAck(dmaAck),
        .adcStart(adcStart), .adcSelTimer(adcSel), .convCnt(convCnt));

    always #2 clk_sys = ~clk_sys;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Count step for one phase change; the other phase holds its level
    function automatic int qdelta(input qcti_mode_t m,
                                  input logic a0, b0, a1, b1);
        logic ar, af, br, bf, u4, d4;
        ar = ~a0 & a1;
        af = a0 & ~a1;
        br = ~b0 & b1;
        bf = b0 & ~b1;
        u4 = (br & a1) | (bf & ~a1);
        d4 = (bf & a1) | (br & ~a1);
        case (m)
            QCTI_MODE1: return (u4 | (ar & ~b1) | (af & b1)) ? 1 :
                               (d4 | (ar & b1) | (af & ~b1)) ? -1 : 0;
            QCTI_MODE2: return (af & b1) ? 1 : ((af & ~b1) ? -1 : 0);
            QCTI_MODE3: return (af & b1) ? 1 : ((bf & a1) ? -1 : 0);
            default:    return u4 ? 1 : (d4 ? -1 : 0);
        endcase
    endfunction

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask

    task automatic final_report();
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Avalon request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        address   <= a;
        writedata <= d;
        write     <= wr;
        read      <= ~wr;
        do begin
            @(posedge clk_sys);
            n++;
            if (n > 20) begin
                error_cnt++;
                final_report();
            end
        end while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read  <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] e,
                         input logic [31:0] m = 32'hFFFFFFFF);
        bus(1'b0, a, '0);
        chk($sformatf("reg %h", a), e, rd & m);
    endtask

    initial begin
        repeat (30000) @(posedge clk_sys);
        error_cnt++;
        final_report();
    end

    initial begin
        logic [ADDR_W-1:0] a, ena, sta;
        logic [15:0]       cnt [2];
        logic [2:0]        fl [2];
        logic              a0, b0, a1, b1;
        int                d, ch, bt, n;
        cnt = '{16'h0000, 16'h0000};
        fl  = '{3'h4, 3'h4};
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 10; i++) begin
            a = ADDR_W'(4 * i);
            rdchk(a, (a == OFF_STAT1 || a == OFF_STAT2) ? 32'h40 : 32'h0);
        end
        bus(1'b1, 8'h24, 32'h000000FF);
        rdchk(8'h24, 32'h0);
        for (int c = 0; c < 2; c++) begin
            for (int m = 0; m < 4; m++) begin
                bus(1'b1, OFF_CTRL, 32'(m * 2 + 1) << (4 * c));
                for (int k = 0; k < 40; k++) begin
                    seed = xs(seed);
                    a0 = c ? phaseInC : phaseInA;
                    b0 = c ? phaseInD : phaseInB;
                    stepCh  <= c[0];
                    stepFwd <= seed[0];
                    stepGo  <= 1'b1;
                    @(posedge clk_sys);
                    stepGo <= 1'b0;
                    repeat (5) @(posedge clk_sys);
                    a1 = c ? phaseInC : phaseInA;
                    b1 = c ? phaseInD : phaseInB;
                    d = qdelta(qcti_mode_t'(m), a0, b0, a1, b1);
                    if (d > 0 && cnt[c] == 16'hFFFF) fl[c][0] = 1'b1;
                    if (d < 0 && cnt[c] == 16'h0000) fl[c][1] = 1'b1;
                    if (d != 0) fl[c][2] = d > 0;
                    cnt[c] = cnt[c] + 16'(d);
                end
                a = OFF_CNT1 + ADDR_W'(4 * c);
                rdchk(a, cnt[c], 32'hFFFF);
                sta = OFF_STAT1 + ADDR_W'(4 * c);
                rdchk(sta, 32'(fl[c]) << 4, 32'h70);
                bus(1'b1, sta, 32'h0);
                fl[c][1:0] = 2'h0;
            end
            cntClear[c] <= 1'b1;
            @(posedge clk_sys);
            cntClear <= '0;
            @(posedge clk_sys);
            cnt[c] = 16'h0000;
            rdchk(OFF_CNT1 + ADDR_W'(4 * c), 32'h0);
        end
        for (int s = 0; s < NSRC; s++) begin
            ch = s < 5 ? 0 : (s < 9 ? 1 : 2);
            bt = s - (ch == 0 ? 0 : (ch == 1 ? 5 : 9));
            if (ch > 0 && bt > 1) bt = bt + 2;
            ena = OFF_ENA0 + ADDR_W'(4 * ch);
            sta = OFF_STAT0 + ADDR_W'(4 * ch);
            adcSel <= s[0];
            bus(1'b1, ena, (32'h1 << bt) | 32'h80);
            if (bt < 4) matchEvt[4 * ch + bt] <= 1'b1;
            else if (bt == 4) ovfEvt[ch] <= 1'b1;
            else unfEvt[ch - 1] <= 1'b1;
            @(posedge clk_sys);
            matchEvt <= '0;
            ovfEvt   <= '0;
            unfEvt   <= '0;
            #1 chk("adcStart", bt == 0 ? 1 << ch : 0, adcStart);
            @(posedge clk_sys);
            #1 chk("irqReq", 1 << s, irqReq);
            chk("irq", 1, irq);
            chk("irqVector", s, irqVector);
            chk("dmaReq", bt == 0 ? 1 << ch : 0, dmaReq);
            @(posedge clk_sys);
            bus(1'b1, ena, 32'h80);
            #1 chk("irq", 0, irq);
            @(posedge clk_sys);
            rdchk(sta, 32'h1 << bt, 32'h3F);
            bus(1'b1, sta, 32'h0);
            rdchk(sta, 32'h0, 32'h3F);
            bus(1'b1, ena, 32'h1 << bt);
            #1 chk("irq", 0, irq);
            @(posedge clk_sys);
        end
        chk("convCnt", 2, convCnt);
        bus(1'b1, OFF_ENA1, 32'h02);
        bus(1'b1, OFF_ENA2, 32'h10);
        matchEvt[5] <= 1'b1;
        ovfEvt[2]   <= 1'b1;
        @(posedge clk_sys);
        matchEvt <= '0;
        ovfEvt   <= '0;
        @(posedge clk_sys);
        #1 chk("irqVector", 6, irqVector);
        chk("irqReq", 32'h0840, irqReq);
        @(posedge clk_sys);
        for (int i = 0; i < 2; i++) begin
            dmaEn   <= 1'b1;
            dmaSlow <= i[0];
            bus(1'b1, OFF_ENA1, 32'h01);
            matchEvt[4] <= 1'b1;
            @(posedge clk_sys);
            matchEvt <= '0;
            repeat (3) @(posedge clk_sys);
            n = 0;
            while (dmaReq[1] !== 1'b0 && n < 40) begin
                @(posedge clk_sys);
                n++;
            end
            chk("dmaReq", 0, dmaReq[1]);
            rdchk(OFF_STAT1, 32'h0, 32'h01);
        end
        final_report();
    end
endmodule // quadrature_count_and_timer_irq_tb
`default_nettype wire
